//--- rtl/slpc_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// - Armed sleep request enters selected state.
// - Enabled wake runs handler, then resumes.
// - Higher priority pending handlers run first.
// - CPU halted four cycles after wake.
// - Stopped clock source adds start-up wait.
// - State kept in sleep; reset restarts.
// - Idle stops CPU and NVM only.
// - Deep halt stops every clock.
// - Deep halt wakes on TWI, port, USB.
// - RTC variant adds RTC clock and wake.
// - Oscillator variant keeps system clock source.
// - Oscillator with RTC keeps both running.
// - Gate bit stops and freezes peripheral.
// - Clearing gate bit resumes peripheral.
// - Gate bits of absent peripherals ignored.
// - Deep sleeps stop peripherals, ADC, comparator.
// - Comparator reference stays on when used.
// - ADC restart makes next conversion long.
// - Port input buffers off without peripheral clock.
// - Watchdog and fused brownout keep running.
// - Control upper bits read zero; reset zero.
// - Selector codes 000, 010, 011, 110, 111.
// - Sleep needs the arm bit set.
`include "slpc_cfg.svh"

module slpc_ctrl #(
    parameter int NPER = 8,
    parameter logic [NPER-1:0] PRESENT = '1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic sleep_req,
    input wire slpc_pkg::slpc_wake_t wake_in,
    input wire logic osc_ready,
    input wire logic rtc_on,
    input wire logic wdt_en,
    input wire logic bod_fuse_en,
    input wire logic adc_conv_done,
    output slpc_pkg::slpc_clk_t clk_en,
    output logic [NPER-1:0] periph_clk_en,
    output logic [NPER-1:0] periph_io_block,
    output logic adc_enable,
    output logic ac_enable,
    output logic vref_enable,
    output logic adc_long_conv,
    output logic port_buf_en,
    output logic wdt_run,
    output logic bod_run,
    output logic sleep_done,
    output logic wake_pulse,
    output slpc_pkg::slpc_wake_t wake_src
);

    // ------------------------------------------------------------
    // State of the whole controller.
    // ------------------------------------------------------------
    typedef struct packed {
        slpc_pkg::slpc_fsm_t fsm;
        logic [2:0] sel;
        logic arm;
        logic [2:0] sleep_state_select;
        logic [2:0] cnt;
        logic osc_low;
        logic [NPER-1:0] gate;
        logic [2:0] ana;
        slpc_pkg::slpc_wake_t w1;
        slpc_pkg::slpc_wake_t w2;
        logic osc1;
        logic osc2;
        slpc_pkg::slpc_clk_t clk;
        logic [NPER-1:0] per_en;
        logic adc_on;
        logic ac_on;
        logic vref_on;
        logic adc_long;
        logic wdt;
        logic bod;
        logic done;
        logic wake;
        slpc_pkg::slpc_wake_t wsrc;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } slpc_state_t;

    slpc_state_t st_r;
    slpc_state_t st_nxt;
    logic acc_first;
    logic acc_done;
    logic deep;

    // ------------------------------------------------------------
    // Mode decoding.
    // ------------------------------------------------------------

    // Reserved codes behave as idle, the safest choice.
    function automatic logic idle_like(input logic [2:0] m);
        return !(m == `SLPC_M_DEEP || m == `SLPC_M_DEEP_RTC ||
                 m == `SLPC_M_OSC || m == `SLPC_M_OSC_RTC);
    endfunction

    function automatic logic rtc_keep(input logic [2:0] m);
        return m == `SLPC_M_DEEP_RTC || m == `SLPC_M_OSC_RTC;
    endfunction

    function automatic logic sys_keep(input logic [2:0] m);
        return idle_like(m) || m == `SLPC_M_OSC ||
               m == `SLPC_M_OSC_RTC;
    endfunction

    // Clock enables for a phase and selected state.
    function automatic slpc_pkg::slpc_clk_t clk_for(
        input slpc_pkg::slpc_fsm_t f,
        input logic [2:0] m,
        input logic rtc
    );
        slpc_pkg::slpc_clk_t c;
        c = '1;
        if (f == slpc_pkg::S_SLEEP || f == slpc_pkg::S_OSC_WAIT) begin
            c.cpu = 1'b0;
            c.nvm = 1'b0;
            if (!idle_like(m)) begin
                c.per = 1'b0;
                c.rtc = rtc_keep(m) & rtc;
                c.rtc_src = rtc_keep(m);
                c.sys_src = sys_keep(m) ||
                            f == slpc_pkg::S_OSC_WAIT;
            end
        end else if (f == slpc_pkg::S_HALT) begin
            c.cpu = 1'b0;
        end
        return c;
    endfunction

    // Whether a wake request is accepted in the selected state.
    function automatic logic wake_ok(
        input logic [2:0] m,
        input slpc_pkg::slpc_wake_t w,
        input logic rtc
    );
        if (idle_like(m))
            return w.any;
        return w.usb || w.port || w.twi ||
               (rtc_keep(m) && rtc && w.rtc);
    endfunction

    // ------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------

    // APB access: the first access cycle raises pready with read
    // data; the write lands on the edge that completes the access,
    // so nothing changes before the master sees pready.
    always_comb begin
        st_nxt = st_r;
        acc_first = psel & penable & ~st_r.pready;
        acc_done = psel & penable & st_r.pready;
        st_nxt.done = 1'b0;
        st_nxt.wake = 1'b0;
        st_nxt.pready = acc_first;
        st_nxt.pslverr = 1'b0;
        st_nxt.prdata = '0;
        // Wake requests and oscillator ready are asynchronous pins.
        st_nxt.w1 = wake_in;
        st_nxt.w2 = st_r.w1;
        st_nxt.osc1 = osc_ready;
        st_nxt.osc2 = st_r.osc1;
        if (acc_first) begin
            case (paddr)
                `SLPC_OFS_CTRL:
                    st_nxt.prdata = {28'h0, st_r.sel, st_r.arm};
                `SLPC_OFS_GATE: st_nxt.prdata = 32'(st_r.gate);
                `SLPC_OFS_ANA: st_nxt.prdata = {29'h0, st_r.ana};
                `SLPC_OFS_STAT:
                    st_nxt.prdata = {26'h0, st_r.adc_long, st_r.sleep_state_select,
                                     st_r.fsm};
                default: st_nxt.pslverr = 1'b1;
            endcase
        end
        if (acc_done && pwrite) begin
            case (paddr)
                `SLPC_OFS_CTRL: begin
                    // Upper bits are dropped, so they stay zero.
                    st_nxt.arm = pwdata[`SLPC_CTRL_ARM];
                    st_nxt.sel = pwdata[`SLPC_CTRL_MODE_HI:`SLPC_CTRL_MODE_LO];
                end
                `SLPC_OFS_GATE:
                    st_nxt.gate = pwdata[NPER-1:0] & PRESENT;
                `SLPC_OFS_ANA: st_nxt.ana = pwdata[2:0];
                default: ;
            endcase
        end

        // Sleep sequencer. Only the halt counter cnt is cleared on wake, so
        // all other state survives a sleep; only rst_n restarts.
        case (st_r.fsm)
            slpc_pkg::S_ACTIVE: begin
                if (sleep_req && st_r.arm) begin
                    st_nxt.fsm = slpc_pkg::S_SLEEP;
                    st_nxt.sleep_state_select = st_r.sel;
                    st_nxt.osc_low = 1'b0;
                end
                st_nxt.done = sleep_req & ~st_r.arm;
            end
            slpc_pkg::S_SLEEP: begin
                if (!st_r.osc2)
                    st_nxt.osc_low = 1'b1;
                if (wake_ok(st_r.sleep_state_select, st_r.w2, rtc_on)) begin
                    st_nxt.wsrc = st_r.w2;
                    st_nxt.cnt = 3'h0;
                    st_nxt.fsm = sys_keep(st_r.sleep_state_select) ? slpc_pkg::S_HALT
                                 : slpc_pkg::S_OSC_WAIT;
                end
            end
            slpc_pkg::S_OSC_WAIT: begin
                // A ready level still high from before the stop is
                // stale; wait until it has been seen low once.
                if (!st_r.osc2)
                    st_nxt.osc_low = 1'b1;
                if (st_r.osc2 && st_r.osc_low)
                    st_nxt.fsm = slpc_pkg::S_HALT;
            end
            slpc_pkg::S_HALT: begin
                st_nxt.cnt = st_r.cnt + 3'h1;
                if (st_r.cnt == `SLPC_HALT_CYC - 3'h1) begin
                    st_nxt.fsm = slpc_pkg::S_ACTIVE;
                    // The CPU's interrupt controller takes all pending
                    // requests by priority, then returns past sleep.
                    st_nxt.wake = 1'b1;
                    st_nxt.done = 1'b1;
                end
            end
            default: st_nxt.fsm = slpc_pkg::S_ACTIVE;
        endcase

        // Outputs follow the next phase, so they line up with fsm.
        deep = (st_nxt.fsm == slpc_pkg::S_SLEEP ||
                st_nxt.fsm == slpc_pkg::S_OSC_WAIT) &&
               !idle_like(st_nxt.sleep_state_select);
        st_nxt.clk = clk_for(st_nxt.fsm, st_nxt.sleep_state_select, rtc_on);
        // A gated peripheral simply loses its clock, so it resumes
        // from the frozen state when the bit clears.
        st_nxt.per_en = {NPER{st_nxt.clk.per}} & ~st_nxt.gate
                        & PRESENT;
        st_nxt.adc_on = st_nxt.ana[`SLPC_ANA_ADC] & ~deep;
        st_nxt.ac_on = st_nxt.ana[`SLPC_ANA_AC] & ~deep;
        // The reference is held even in deep sleep when the
        // comparator uses it; software should turn it off first.
        st_nxt.vref_on = st_nxt.ana[`SLPC_ANA_AC] &
                         st_nxt.ana[`SLPC_ANA_VREF];
        // Setting wins over the conversion-done clear.
        if (st_nxt.adc_on && !st_r.adc_on)
            st_nxt.adc_long = 1'b1;
        else if (adc_conv_done)
            st_nxt.adc_long = 1'b0;
        st_nxt.wdt = wdt_en;
        st_nxt.bod = bod_fuse_en;
    end

    // ------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------

    // Reset clears all but the clock enables, which load running, including a reset taken asleep.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.fsm <= slpc_pkg::S_ACTIVE;
            {st_r.sel, st_r.arm} <= `SLPC_CTRL_RST;
            st_r.ana <= `SLPC_ANA_RST;
            st_r.clk <= '1;
            st_r.per_en <= PRESENT;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from the state register.
    // ------------------------------------------------------------
    assign pready = st_r.pready;
    assign prdata = st_r.prdata;
    assign pslverr = st_r.pslverr;
    assign clk_en = st_r.clk;
    assign periph_clk_en = st_r.per_en;
    assign periph_io_block = st_r.gate;
    assign adc_enable = st_r.adc_on;
    assign ac_enable = st_r.ac_on;
    assign vref_enable = st_r.vref_on;
    assign adc_long_conv = st_r.adc_long;
    assign port_buf_en = st_r.clk.per;
    assign wdt_run = st_r.wdt;
    assign bod_run = st_r.bod;
    assign sleep_done = st_r.done;
    assign wake_pulse = st_r.wake;
    assign wake_src = st_r.wsrc;

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_halt_hold;
        !clk_en.cpu [*4];
    endsequence
    sequence s_resume;
        clk_en.cpu && wake_pulse && sleep_done;
    endsequence

    a_halt_four: assert property (
        $rose(st_r.fsm == slpc_pkg::S_HALT) |-> s_halt_hold ##1 s_resume)
        else $error("CPU halt after wake is not four cycles.");
    a_sleep_enter: assert property (
        st_r.fsm == slpc_pkg::S_ACTIVE && sleep_req && st_r.arm
        |=> !clk_en.cpu && st_r.sleep_state_select == $past(st_r.sel))
        else $error("Armed sleep request did not stop the CPU.");
    a_unarmed_pass: assert property (
        st_r.fsm == slpc_pkg::S_ACTIVE && sleep_req && !st_r.arm
        |=> sleep_done && clk_en.cpu)
        else $error("Unarmed sleep request did not continue.");
    a_deep_clocks: assert property (
        st_r.fsm == slpc_pkg::S_SLEEP && st_r.sleep_state_select == `SLPC_M_DEEP
        |-> clk_en == '0 && !port_buf_en && !adc_enable)
        else $error("Deep halt left a clock or input buffer running.");
    a_deep_no_rtc: assert property (
        st_r.fsm == slpc_pkg::S_SLEEP && st_r.sleep_state_select == `SLPC_M_DEEP &&
        !st_r.w2.usb && !st_r.w2.port && !st_r.w2.twi
        |=> st_r.fsm == slpc_pkg::S_SLEEP)
        else $error("Deep halt woke on a source it must ignore.");
    a_rtc_wakes: assert property (
        st_r.fsm == slpc_pkg::S_SLEEP &&
        st_r.sleep_state_select == `SLPC_M_DEEP_RTC && st_r.w2.rtc && rtc_on
        |=> st_r.fsm == slpc_pkg::S_OSC_WAIT ##5 !clk_en.cpu)
        else $error("RTC interrupt did not wake the RTC sleep state.");
    a_idle_runs: assert property (
        st_r.fsm == slpc_pkg::S_SLEEP && idle_like(st_r.sleep_state_select)
        |-> !clk_en.cpu && !clk_en.nvm && clk_en.per && clk_en.sys_src)
        else $error("Idle sleep gated the wrong clocks.");
    a_osc_wait: assert property (
        st_r.fsm == slpc_pkg::S_OSC_WAIT && !st_r.osc2
        |=> st_r.fsm == slpc_pkg::S_OSC_WAIT && clk_en.sys_src)
        else $error("CPU resumed before the clock source was ready.");
    a_gate_absent: assert property (
        (periph_clk_en & ~PRESENT) == '0 && (st_r.gate & ~PRESENT) == '0)
        else $error("Gate bit of an absent peripheral took effect.");
    a_adc_long: assert property (
        $rose(adc_enable) |-> adc_long_conv)
        else $error("ADC restart did not request a long conversion.");
    a_ctrl_upper: assert property (
        pready && $past(paddr) == `SLPC_OFS_CTRL && !$past(pwrite)
        |-> prdata[31:4] == 28'h0)
        else $error("Control register upper bits read nonzero.");

endmodule

//--- rtl/slpc_cfg.svh
`ifndef SLPC_CFG_SVH
`define SLPC_CFG_SVH

// ----------------------------------------------------------------
// Register offsets on the APB window.
// ----------------------------------------------------------------
`define SLPC_OFS_CTRL 8'h00
`define SLPC_OFS_GATE 8'h04
`define SLPC_OFS_ANA 8'h08
`define SLPC_OFS_STAT 8'h0C

// ----------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------
`define SLPC_CTRL_ARM 0
`define SLPC_CTRL_MODE_LO 1
`define SLPC_CTRL_MODE_HI 3
`define SLPC_ANA_ADC 0
`define SLPC_ANA_AC 1
`define SLPC_ANA_VREF 2
`define SLPC_CTRL_RST 4'h0
`define SLPC_ANA_RST 3'h0

// ----------------------------------------------------------------
// Sleep state selector codes; 001, 100 and 101 are reserved.
// ----------------------------------------------------------------
`define SLPC_M_IDLE 3'h0
`define SLPC_M_DEEP 3'h2
`define SLPC_M_DEEP_RTC 3'h3
`define SLPC_M_OSC 3'h6
`define SLPC_M_OSC_RTC 3'h7

// ----------------------------------------------------------------
// Timing: CPU halt after wake, in system clock cycles.
// ----------------------------------------------------------------
`define SLPC_HALT_CYC 3'h4

`endif

//--- rtl/slpc_pkg.sv
package slpc_pkg;

    // Controller phase: running, asleep, waiting for the clock
    // source to start, and the post-wake CPU halt.
    typedef enum logic [1:0] {
        S_ACTIVE,
        S_SLEEP,
        S_OSC_WAIT,
        S_HALT
    } slpc_fsm_t;

    // Clock domain and oscillator enables, high means running.
    typedef struct packed {
        logic cpu;
        logic nvm;
        logic per;
        logic rtc;
        logic sys_src;
        logic rtc_src;
    } slpc_clk_t;

    // Wake-capable interrupt requests.
    typedef struct packed {
        logic usb;
        logic port;
        logic twi;
        logic rtc;
        logic any;
    } slpc_wake_t;

endpackage

//--- bench/slpc_cpu_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// CPU core stand-in: issues the sleep instruction and serves wakes.
// ----------------------------------------------------------------
module slpc_cpu_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic go,
    input wire logic sleep_done,
    input wire logic wake_pulse,
    input wire slpc_pkg::slpc_wake_t wake_src,
    output logic sleep_req,
    output logic busy,
    output logic [2:0] isr
);
    // Fetch stalls on the sleep instruction until it retires, so a
    // second request can never overlap the first one.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sleep_req <= 1'b0;
            busy <= 1'b0;
            isr <= 3'h0;
        end else begin
            sleep_req <= go && !busy;
            if (go && !busy) begin
                busy <= 1'b1;
            end else if (sleep_done) begin
                busy <= 1'b0;
            end
            // The highest pending source is served first.
            if (sleep_done && wake_pulse) begin
                isr <= wake_src.usb ? 3'h4 : wake_src.port ? 3'h3 :
                    wake_src.twi ? 3'h2 : wake_src.rtc ? 3'h1 : 3'h0;
            end
        end
    end
endmodule

//--- bench/test_slpc_ctrl.sv
`timescale 1ns/1ps
`include "slpc_cfg.svh"
module test_slpc_ctrl;
    localparam logic [7:0] PRES = 8'h7F;
    localparam int OSC_START = 20;
    logic clock, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, periph_clk_en, periph_io_block;
    logic [31:0] pwdata, prdata, rd;
    logic sleep_req, osc_ready, adc_conv_done, go, busy;
    logic rtc_on, wdt_en, bod_fuse_en;
    logic adc_enable, ac_enable, vref_enable, adc_long_conv, port_buf_en;
    logic wdt_run, bod_run, sleep_done, wake_pulse;
    logic [2:0] isr;
    slpc_pkg::slpc_wake_t wake_in, wake_src;
    slpc_pkg::slpc_clk_t clk_en;
    int error_cnt, check_count, osc_cnt;

    slpc_ctrl #(.NPER(8), .PRESENT(PRES)) u_dut (
        .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .sleep_req(sleep_req),
        .wake_in(wake_in), .osc_ready(osc_ready), .rtc_on(rtc_on),
        .wdt_en(wdt_en), .bod_fuse_en(bod_fuse_en),
        .adc_conv_done(adc_conv_done),
        .clk_en(clk_en), .periph_clk_en(periph_clk_en),
        .periph_io_block(periph_io_block), .adc_enable(adc_enable),
        .ac_enable(ac_enable), .vref_enable(vref_enable),
        .adc_long_conv(adc_long_conv), .port_buf_en(port_buf_en),
        .wdt_run(wdt_run), .bod_run(bod_run), .sleep_done(sleep_done),
        .wake_pulse(wake_pulse), .wake_src(wake_src));

    slpc_cpu_model u_cpu (.clock(clock), .rst_n(rst_n), .go(go),
        .sleep_done(sleep_done), .wake_pulse(wake_pulse),
        .wake_src(wake_src), .sleep_req(sleep_req), .busy(busy),
        .isr(isr));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Oscillator stand-in: ready only after a start-up count, so a
    // wake from a stopped source must visibly take longer.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n || !clk_en.sys_src) osc_cnt <= 0;
        else if (osc_cnt < OSC_START) osc_cnt <= osc_cnt + 1;
    end
    assign osc_ready = (osc_cnt == OSC_START);

    // ----------------------------------------------------------------
    // Bus and compare tasks.
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Request is held until pready is sampled high, then released.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        // Wait as long as the slave needs; the watchdog bounds it.
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic sleep_go;
        @(posedge clock);
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
    endtask

    function automatic logic [5:0] exp_clk(input logic [2:0] m);
        case (m)
            `SLPC_M_IDLE: return 6'h0F;
            `SLPC_M_DEEP: return 6'h00;
            `SLPC_M_DEEP_RTC: return rtc_on ? 6'h05 : 6'h01;
            `SLPC_M_OSC: return 6'h02;
            default: return rtc_on ? 6'h07 : 6'h03;
        endcase
    endfunction

    // Source the CPU serves first: USB, port, two-wire, then RTC.
    function automatic logic [2:0] top_src(input logic [4:0] w);
        for (int i = 4; i >= 1; i--) begin
            if (w[i]) return 3'(i);
        end
        return 3'h0;
    endfunction

    // ----------------------------------------------------------------
    // One armed sleep: a refused source first, then the waking one.
    // ----------------------------------------------------------------
    task automatic nap(input logic [2:0] m, input logic [4:0] good,
                       input logic [4:0] bad);
        int lat;
        int halt;
        logic idle;
        logic deep;
        idle = (m == `SLPC_M_IDLE);
        deep = (m == `SLPC_M_DEEP) || (m == `SLPC_M_DEEP_RTC);
        lat = 0;
        halt = 0;
        apb(1'b1, `SLPC_OFS_ANA, 32'h7);
        @(posedge clock);
        adc_conv_done <= 1'b1;
        @(posedge clock);
        adc_conv_done <= 1'b0;
        apb(1'b1, `SLPC_OFS_CTRL, {28'h0, m, 1'b1});
        sleep_go();
        cyc(3);
        chk(32'(clk_en), 32'(exp_clk(m)));
        chk(32'(port_buf_en), 32'(idle));
        chk(32'({adc_enable, ac_enable}), 32'({idle, idle}));
        chk(32'(vref_enable), 32'h1);
        chk(32'({wdt_run, bod_run}), 32'h2);
        chk(32'(periph_clk_en), idle ? 32'(PRES) : 32'h0);
        wake_in <= bad;
        cyc(8);
        chk(32'(clk_en.cpu), 32'h0);
        wake_in <= 5'h00;
        cyc(3);
        wake_in <= good;
        while (sleep_done !== 1'b1 && lat < 200) begin
            @(posedge clock);
            lat++;
            if (clk_en.cpu === 1'b0 && clk_en.per === 1'b1 && !idle && !deep)
                halt++;
        end
        chk(32'(wake_pulse), 32'h1);
        chk(32'(wake_src), 32'(good));
        chk(32'(clk_en), 32'h3F);
        if (!idle && !deep) chk(32'(halt), 32'h4);
        chk(32'(lat > OSC_START), 32'(deep));
        wake_in <= 5'h00;
        cyc(2);
        chk(32'(adc_long_conv), 32'(!idle));
        chk(32'(isr), 32'(top_src(good)));
        apb(1'b0, `SLPC_OFS_CTRL, 32'h0);
        chk(rd, {28'h0, m, 1'b1});
    endtask

    task automatic wrap_up;
        $display("Checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Whole run is well under two thousand cycles.
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        wrap_up();
    end

    // ----------------------------------------------------------------
    // Main sequence.
    // ----------------------------------------------------------------
    initial begin
        {rst_n, psel, penable, pwrite, go, adc_conv_done} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        wake_in = 5'h00;
        {rtc_on, wdt_en, bod_fuse_en} = 3'h6;
        error_cnt = 0;
        check_count = 0;
        cyc(2);
        rst_n <= 1'b1;
        apb(1'b0, `SLPC_OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `SLPC_OFS_ANA, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `SLPC_OFS_CTRL, 32'hFFFF_FFF0);
        apb(1'b0, `SLPC_OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `SLPC_OFS_CTRL, 32'hE);
        sleep_go();
        cyc(2);
        chk(32'({sleep_done, wake_pulse}), 32'h2);
        chk(32'(clk_en), 32'h3F);
        apb(1'b1, `SLPC_OFS_GATE, 32'hFF);
        apb(1'b0, `SLPC_OFS_GATE, 32'h0);
        chk(rd, 32'(PRES));
        chk(32'(periph_clk_en), 32'h0);
        chk(32'(periph_io_block), 32'(PRES));
        apb(1'b1, `SLPC_OFS_GATE, 32'h0);
        cyc(1);
        chk(32'(periph_clk_en), 32'(PRES));
        apb(1'b0, 8'h10, 32'h0);
        chk(32'(err), 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, `SLPC_OFS_STAT, 32'hFF);
        apb(1'b0, `SLPC_OFS_STAT, 32'h0);
        chk(32'({err, rd[1:0]}), 32'h0);
        nap(`SLPC_M_IDLE, 5'h01, 5'h00);
        nap(`SLPC_M_DEEP, 5'h04, 5'h03);
        nap(`SLPC_M_DEEP_RTC, 5'h02, 5'h01);
        nap(`SLPC_M_OSC, 5'h08, 5'h03);
        nap(`SLPC_M_OSC_RTC, 5'h18, 5'h01);
        rtc_on <= 1'b0;
        nap(`SLPC_M_DEEP_RTC, 5'h04, 5'h02);
        apb(1'b1, `SLPC_OFS_CTRL, 32'h5);
        sleep_go();
        cyc(3);
        chk(32'(clk_en), 32'h0);
        rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        cyc(1);
        chk(32'(clk_en), 32'h3F);
        apb(1'b0, `SLPC_OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        wrap_up();
    end
endmodule
